/* File: rtl/dpvs_core.sv */
// Contract
// - each phase switches at oscillator rate, 150kHz
// - oscillator stopped input halts all switching
// - open code pin reads one; ground is zero
// - code picks 0.800-1.550V set-point, 25mV steps
// - code 11111 latches park: gates off, unprotected
// - ok window and trips follow programmed code
// - sample code once per switching period
// - accept new code only after stable >1 period
// - reference steps one code per period to target
// - ignore code changes while stepping
// - mask ok while stepping; trips stay armed
// - node below 2V, then low gate after 30ns
// - low gate below 1V, then high after 30ns
// - node stuck 240ns: low side on anyway
// - sample current late in off time, track>=200ns
// - total, mean current; correct each phase on-time
// - phase reading above 35uA flags overcurrent
// - on-time limit 0.80T at zero, 0.40T at limit
// - overcurrent: hold low side, skip periods
// - under 60% for >1 period: off, fault, latch
// - ok low for 2048 periods, then window check
// - over-voltage: stop, low sides on, fault
`timescale 1ns/1ps
module dpvs_core #(
  parameter int PER = dpvs_pkg::PER_CYC,
  parameter int SS_TICKS = dpvs_pkg::SS_TICKS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // asynchronous pins and comparators
  input wire logic [4:0] voltage_code_i,
  input wire logic freq_stop_i,
  input wire logic [1:0] switch_node_low_i,
  input wire logic [1:0] low_gate_low_i,
  // synchronous converter readings
  input wire logic signed [7:0] phase_current_info_i [2],
  input wire logic [10:0] vout_mv_i,
  input wire logic [7:0] ton_demand_i,
  // power stage and status
  output dpvs_pkg::dpvs_drive_t drive_o [2],
  output logic fault_o,
  output logic output_ok_o,
  output logic no_load_park_mode_o,
  output logic [10:0] setpoint_ref_o,
  output logic signed [8:0] total_current_info_o,
  output logic signed [7:0] mean_phase_current_o
);
  localparam int TW = 8;
  localparam logic [TW-1:0] PER_M1 = TW'(PER - 1);
  localparam logic [TW-1:0] HALF = TW'(PER / 2);
  localparam logic [TW-1:0] SHIFT1 = TW'(PER - PER / 2);
  localparam logic [11:0] SS_LAST = 12'(SS_TICKS - 1);

  function automatic logic [10:0] code_mv(input logic [4:0] c);
    code_mv = 11'(dpvs_pkg::VMAX_MV - dpvs_pkg::STEP_MV * int'(c));
  endfunction

  function automatic logic [17:0] pct(input logic [10:0] mv,
                                      input int p);
    pct = 18'((int'(mv) * p) / 100);
  endfunction

  function automatic logic [TW-1:0] ton_limit(
      input logic signed [8:0] itot);
    int i;
    int p;
    i = int'(itot);
    if (i < 0) i = 0;
    if (i > dpvs_pkg::ITOT_OC_UA) i = dpvs_pkg::ITOT_OC_UA;
    p = dpvs_pkg::TON_ZERO_PCT * dpvs_pkg::ITOT_OC_UA
      - (dpvs_pkg::TON_ZERO_PCT - dpvs_pkg::TON_OC_PCT) * i;
    ton_limit = TW'((PER * p) / (100 * dpvs_pkg::ITOT_OC_UA));
  endfunction

  // synchroniser, second stage is the only reader of the first
  logic [9:0] meta;
  logic [9:0] syn;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= 10'h3E0;
      syn <= 10'h3E0;
    end else begin
      meta <= {voltage_code_i, freq_stop_i,
               switch_node_low_i, low_gate_low_i};
      syn <= meta;
    end
  end
  logic [4:0] code_s;
  logic stop_s;
  logic [1:0] node_low_s;
  logic [1:0] lgate_low_s;
  assign code_s = syn[9:5];
  assign stop_s = syn[4];
  assign node_low_s = syn[3:2];
  assign lgate_low_s = syn[1:0];

  // switching oscillator
  logic [TW-1:0] div;
  logic tick;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div <= '0;
    end else if (!stop_s) begin
      div <= (div == PER_M1) ? '0 : div + 1'b1;
    end
  end
  assign tick = (div == PER_M1) && !stop_s;

  logic [TW-1:0] pos [2];
  logic [1:0] start;
  always_comb begin
    pos[0] = div;
    pos[1] = (div < HALF) ? div + SHIFT1 : div - HALF;
    start[0] = (pos[0] == '0) && !stop_s;
    start[1] = (pos[1] == '0) && !stop_s;
  end

  // voltage code tracking
  logic init_done;
  logic [4:0] samp;
  logic [1:0] stab;
  logic [4:0] target;
  logic [4:0] refc;
  logic [4:0] next_refc;
  logic stepping;
  logic park;
  assign next_refc = (refc < target) ? refc + 5'h01 : refc - 5'h01;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      init_done <= 1'b0;
      samp <= dpvs_pkg::PARK_CODE;
      stab <= '0;
      target <= '0;
      refc <= '0;
      stepping <= 1'b0;
      park <= 1'b0;
    end else if (tick) begin
      samp <= code_s;
      if (!init_done) begin
        init_done <= 1'b1;
        target <= code_s;
        refc <= code_s;
        park <= (code_s == dpvs_pkg::PARK_CODE);
      end else if (stepping) begin
        refc <= next_refc;
        stepping <= (next_refc != target);
        stab <= '0;
      end else if (code_s == samp && code_s != target) begin
        if (stab == 2'(dpvs_pkg::STABLE_TICKS - 1)) begin
          stab <= '0;
          if (code_s == dpvs_pkg::PARK_CODE) begin
            park <= 1'b1;
          end else begin
            target <= code_s;
            stepping <= 1'b1;
          end
        end else begin
          stab <= stab + 2'h1;
        end
      end else begin
        stab <= '0;
      end
    end
  end

  // set-point and thresholds
  logic [10:0] ref_mv;
  logic [17:0] ov_th;
  logic [17:0] uv_th;
  logic [17:0] ok_hi;
  logic [17:0] ok_lo;
  logic [17:0] vout_w;
  always_comb begin
    ref_mv = code_mv(refc);
    ov_th = pct(ref_mv, dpvs_pkg::OV_PCT);
    uv_th = pct(ref_mv, dpvs_pkg::UV_PCT);
    ok_hi = pct(ref_mv, 100 + dpvs_pkg::OK_PCT);
    ok_lo = pct(ref_mv, 100 - dpvs_pkg::OK_PCT);
    vout_w = {7'h00, vout_mv_i};
  end

  // soft start and protection
  logic [11:0] ss_cnt;
  logic ss_done;
  logic [1:0] uv_cnt;
  logic uv_fault;
  logic ov_fault;
  logic prot_on;
  assign prot_on = init_done && !park;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ss_cnt <= '0;
      ss_done <= 1'b0;
    end else if (tick && init_done && !ss_done) begin
      ss_cnt <= ss_cnt + 12'h001;
      ss_done <= (ss_cnt == SS_LAST);
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      uv_cnt <= '0;
      uv_fault <= 1'b0;
      ov_fault <= 1'b0;
    end else begin
      if (prot_on && vout_w > ov_th) begin
        ov_fault <= 1'b1;
      end
      if (tick) begin
        if (prot_on && ss_done && vout_w < uv_th) begin
          if (uv_cnt == 2'(dpvs_pkg::UV_TICKS - 1)) begin
            uv_fault <= 1'b1;
          end else begin
            uv_cnt <= uv_cnt + 2'h1;
          end
        end else begin
          uv_cnt <= '0;
        end
      end
    end
  end

  // registers
  logic inhibit;
  logic [2:0] share_sh;
  logic run;
  assign run = init_done && !park && !uv_fault && !ov_fault
            && !inhibit && !stop_s;

  // current sampling and sharing
  logic signed [7:0] cur [2];
  logic [TW-1:0] tcnt [2];
  logic [1:0] oc;
  logic signed [8:0] itot;
  logic signed [7:0] avg;
  logic [TW-1:0] tmax;
  logic [TW-1:0] ton [2];
  dpvs_pkg::dpvs_gate_t gs [2];
  dpvs_pkg::dpvs_gate_t next_gs [2];

  always_comb begin
    logic signed [9:0] t;
    t = '0;
    itot = 9'(cur[0]) + 9'(cur[1]);
    avg = 8'(itot >>> 1);
    tmax = ton_limit(itot);
    for (int p = 0; p < 2; p++) begin
      oc[p] = cur[p] > 8'(dpvs_pkg::OC_UA);
      t = $signed({2'b00, ton_demand_i})
        - ((10'(cur[p]) - 10'(avg)) >>> share_sh);
      if (t < 0) ton[p] = '0;
      else if (t > $signed({2'b00, tmax})) ton[p] = tmax;
      else ton[p] = TW'(t);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int p = 0; p < 2; p++) begin
        cur[p] <= '0;
        tcnt[p] <= '0;
      end
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (start[p]) begin
          if (tcnt[p] >= TW'(dpvs_pkg::TRACK_CYC)) begin
            cur[p] <= phase_current_info_i[p];
          end
          tcnt[p] <= '0;
        end else if (gs[p] == dpvs_pkg::G_LOW
                     && pos[p] >= TW'((9'(ton[p]) + 9'(PER)) >> 1)
                     && tcnt[p] != '1) begin
          tcnt[p] <= tcnt[p] + 1'b1;
        end
      end
    end
  end

  // gate sequencing
  logic [TW-1:0] dcnt [2];
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      next_gs[p] = gs[p];
      case (gs[p])
        dpvs_pkg::G_OFF: begin
          if (ov_fault) next_gs[p] = dpvs_pkg::G_LOW;
          else if (run && start[p])
            next_gs[p] = oc[p] ? dpvs_pkg::G_LOW : dpvs_pkg::G_GATE;
        end
        dpvs_pkg::G_HIGH: begin
          if (!run || pos[p] >= ton[p])
            next_gs[p] = dpvs_pkg::G_NODE;
        end
        dpvs_pkg::G_NODE: begin
          if (node_low_s[p]) next_gs[p] = dpvs_pkg::G_DLO;
          else if (dcnt[p] >= TW'(dpvs_pkg::WDOG_CYC))
            next_gs[p] = dpvs_pkg::G_LOW;
        end
        dpvs_pkg::G_DLO: begin
          if (dcnt[p] >= TW'(dpvs_pkg::DEAD_CYC - 1))
            next_gs[p] = dpvs_pkg::G_LOW;
        end
        dpvs_pkg::G_LOW: begin
          if (ov_fault) next_gs[p] = dpvs_pkg::G_LOW;
          else if (!run) next_gs[p] = dpvs_pkg::G_OFF;
          else if (start[p] && !oc[p])
            next_gs[p] = dpvs_pkg::G_GATE;
        end
        dpvs_pkg::G_GATE: begin
          if (ov_fault) next_gs[p] = dpvs_pkg::G_LOW;
          else if (!run) next_gs[p] = dpvs_pkg::G_OFF;
          else if (lgate_low_s[p])
            next_gs[p] = dpvs_pkg::G_DHI;
        end
        dpvs_pkg::G_DHI: begin
          if (ov_fault) next_gs[p] = dpvs_pkg::G_LOW;
          else if (!run) next_gs[p] = dpvs_pkg::G_OFF;
          else if (dcnt[p] >= TW'(dpvs_pkg::DEAD_CYC - 1))
            next_gs[p] = dpvs_pkg::G_HIGH;
        end
        default: next_gs[p] = dpvs_pkg::G_OFF;
      endcase
    end
  end

  // drives are registered from the next state so both edges align
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int p = 0; p < 2; p++) begin
        gs[p] <= dpvs_pkg::G_OFF;
        dcnt[p] <= '0;
        drive_o[p] <= '0;
      end
    end else begin
      for (int p = 0; p < 2; p++) begin
        gs[p] <= next_gs[p];
        dcnt[p] <= (next_gs[p] != gs[p]) ? '0
                 : (dcnt[p] == '1) ? dcnt[p] : dcnt[p] + 1'b1;
        drive_o[p].high <= (next_gs[p] == dpvs_pkg::G_HIGH);
        drive_o[p].low <= (next_gs[p] == dpvs_pkg::G_LOW);
      end
    end
  end

  // status outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_o <= 1'b0;
      output_ok_o <= 1'b0;
      no_load_park_mode_o <= 1'b0;
      setpoint_ref_o <= '0;
      total_current_info_o <= '0;
      mean_phase_current_o <= '0;
    end else begin
      fault_o <= uv_fault || ov_fault;
      output_ok_o <= ss_done && !stepping && !park
                  && !uv_fault && !ov_fault
                  && vout_w >= ok_lo && vout_w <= ok_hi;
      no_load_park_mode_o <= park;
      setpoint_ref_o <= init_done ? ref_mv : '0;
      total_current_info_o <= itot;
      mean_phase_current_o <= avg;
    end
  end

  // wishbone slave, one wait state
  logic req;
  dpvs_pkg::dpvs_status_t stat;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  always_comb begin
    stat.running = run;
    stat.oc = oc;
    stat.ok = output_ok_o;
    stat.stepping = stepping;
    stat.ov = ov_fault;
    stat.uv = uv_fault;
    stat.park = park;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      inhibit <= 1'b0;
      share_sh <= dpvs_pkg::SHARE_SH_RST;
    end else if (req && wb_we_i && wb_sel_i[0]
                 && wb_adr_i == dpvs_pkg::ADR_CTRL) begin
      inhibit <= wb_dat_i[dpvs_pkg::CTRL_INH];
      share_sh <= wb_dat_i[dpvs_pkg::CTRL_SH_LSB +: 3];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= '0;
      if (req && !wb_we_i) begin
        case (wb_adr_i)
          dpvs_pkg::ADR_CTRL: wb_dat_o <= {28'h0, share_sh, inhibit};
          dpvs_pkg::ADR_STAT: wb_dat_o <= {24'h0, stat};
          dpvs_pkg::ADR_CODE:
            wb_dat_o <= {8'h00, 5'(ref_mv >> 6), 3'h0,
                         3'h0, refc, 3'h0, target};
          dpvs_pkg::ADR_CURR:
            wb_dat_o <= {16'h0000, cur[1], cur[0]};
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end
endmodule

/* File: shared/dpvs_pkg.sv */
package dpvs_pkg;
  // clock and switching rate
  localparam int CLK_HZ = 10_000_000;
  localparam int SW_HZ = 150_000;
  localparam int PER_CYC = CLK_HZ / SW_HZ;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  // gate timing
  localparam int DEAD_NS = 30;
  localparam int DEAD_RAW = (DEAD_NS * CLK_MHZ + 999) / 1000;
  localparam int DEAD_CYC = (DEAD_RAW < 1) ? 1 : DEAD_RAW;
  localparam int WDOG_NS = 240;
  localparam int WDOG_RAW = (WDOG_NS * CLK_MHZ) / 1000;
  localparam int WDOG_CYC = (WDOG_RAW < 1) ? 1 : WDOG_RAW;
  localparam int TRACK_NS = 200;
  localparam int TRACK_RAW = (TRACK_NS * CLK_MHZ + 999) / 1000;
  localparam int TRACK_CYC = (TRACK_RAW < 1) ? 1 : TRACK_RAW;
  // counts in switching periods
  localparam int SS_TICKS = 2048;
  localparam int STABLE_TICKS = 2;
  localparam int UV_TICKS = 2;
  // voltage code
  localparam int CODE_W = 5;
  localparam logic [4:0] PARK_CODE = 5'h1F;
  localparam int VMAX_MV = 1550;
  localparam int STEP_MV = 25;
  localparam int MV_W = 11;
  // currents, in microamps
  localparam int CUR_W = 8;
  localparam int OC_UA = 35;
  localparam int ITOT_OC_UA = 70;
  localparam int TON_ZERO_PCT = 80;
  localparam int TON_OC_PCT = 40;
  // output window, percent of set-point
  localparam int OK_PCT = 12;
  localparam int UV_PCT = 60;
  localparam int OV_PCT = 120;
  // register map
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_STAT = 4'h4;
  localparam logic [3:0] ADR_CODE = 4'h8;
  localparam logic [3:0] ADR_CURR = 4'hC;
  localparam int CTRL_INH = 0;
  localparam int CTRL_SH_LSB = 1;
  localparam logic [2:0] SHARE_SH_RST = 3'h2;

  typedef enum logic [6:0] {
    G_OFF  = 7'h01,
    G_HIGH = 7'h02,
    G_NODE = 7'h04,
    G_DLO  = 7'h08,
    G_LOW  = 7'h10,
    G_GATE = 7'h20,
    G_DHI  = 7'h40
  } dpvs_gate_t;

  typedef struct packed {
    logic high;
    logic low;
  } dpvs_drive_t;

  typedef struct packed {
    logic running;
    logic [1:0] oc;
    logic ok;
    logic stepping;
    logic ov;
    logic uv;
    logic park;
  } dpvs_status_t;
endpackage

/* File: testbench/dpvs_checker.sv */
`timescale 1ns/1ps
module dpvs_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // watched inputs
  input wire logic freq_stop_i,
  input wire logic [10:0] vout_mv_i,
  // watched outputs
  input wire logic wb_ack_o,
  input wire dpvs_pkg::dpvs_drive_t drive_o [2],
  input wire logic fault_o,
  input wire logic output_ok_o,
  input wire logic no_load_park_mode_o,
  input wire logic [10:0] setpoint_ref_o,
  input wire logic signed [8:0] total_current_info_o,
  input wire logic signed [7:0] mean_phase_current_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic ov_hit;
  // trips are armed only once a code has been sampled
  assign ov_hit = int'(vout_mv_i) * 100 > int'(setpoint_ref_o) * 120
    && setpoint_ref_o != 11'h000 && !no_load_park_mode_o;
  sequence s_high_off;
    $fell(drive_o[0].high) && !fault_o && !no_load_park_mode_o
      && !freq_stop_i;
  endsequence
  sequence s_low_on;
    ##[1:8] drive_o[0].low;
  endsequence
  property p_excl;
    !(drive_o[0].high && drive_o[0].low)
      && !(drive_o[1].high && drive_o[1].low);
  endproperty
  a_excl: assert property (p_excl) else $error("gates overlap");
  property p_dead_hi;
    $rose(drive_o[0].high) |-> !$past(drive_o[0].low);
  endproperty
  a_dead_hi: assert property (p_dead_hi) else $error("no gap");
  property p_dead_lo;
    $rose(drive_o[1].low) && !fault_o |-> !$past(drive_o[1].high);
  endproperty
  a_dead_lo: assert property (p_dead_lo) else $error("no gap");
  property p_wdog;
    s_high_off |-> s_low_on;
  endproperty
  a_wdog: assert property (p_wdog) else $error("low late");
  property p_park;
    no_load_park_mode_o |=> no_load_park_mode_o && !fault_o
      && drive_o[0] == 2'b00 && drive_o[1] == 2'b00;
  endproperty
  a_park: assert property (p_park) else $error("park broken");
  property p_fault;
    fault_o |=> fault_o && !drive_o[0].high && !drive_o[1].high;
  endproperty
  a_fault: assert property (p_fault) else $error("fault lost");
  property p_mean;
    mean_phase_current_o == $signed(total_current_info_o[8:1]);
  endproperty
  a_mean: assert property (p_mean) else $error("mean wrong");
  property p_step;
    $changed(setpoint_ref_o) && $past(setpoint_ref_o) != 11'h000 |->
      setpoint_ref_o == $past(setpoint_ref_o) + 11'd25
      || setpoint_ref_o == $past(setpoint_ref_o) - 11'd25;
  endproperty
  a_step: assert property (p_step) else $error("step size");
  property p_ok_mask;
    $changed(setpoint_ref_o) |-> !$past(output_ok_o);
  endproperty
  a_ok_mask: assert property (p_ok_mask) else $error("ok shown");
  property p_ov;
    ov_hit && !fault_o |->
      ##[1:4] fault_o && drive_o[0].low && drive_o[1].low;
  endproperty
  a_ov: assert property (p_ov) else $error("no crowbar");
  property p_halt;
    freq_stop_i [*8] |-> !drive_o[0].high && !drive_o[1].high;
  endproperty
  a_halt: assert property (p_halt) else $error("still on");
  property p_ack;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack long");
endmodule

bind dpvs_core dpvs_checker chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .freq_stop_i(freq_stop_i), .vout_mv_i(vout_mv_i), .wb_ack_o(wb_ack_o),
  .drive_o(drive_o), .fault_o(fault_o), .output_ok_o(output_ok_o),
  .no_load_park_mode_o(no_load_park_mode_o),
  .setpoint_ref_o(setpoint_ref_o),
  .total_current_info_o(total_current_info_o),
  .mean_phase_current_o(mean_phase_current_o));

/* File: testbench/dpvs_core_tb.sv */
`timescale 1ns/1ps
module dpvs_core_tb;
  localparam int PER = 16;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [4:0] voltage_code_i = 5'h04;
  logic freq_stop_i = 1'b0;
  logic [1:0] node_low;
  logic [1:0] gate_low;
  logic signed [7:0] phase_current_info_i [2] = '{8'sh0A, 8'sh0A};
  logic [10:0] vout_mv_i = 11'h000;
  logic [7:0] ton_demand_i = 8'h06;
  dpvs_pkg::dpvs_drive_t drive_o [2];
  logic fault_o, output_ok_o, no_load_park_mode_o;
  logic [10:0] setpoint_ref_o;
  logic signed [8:0] total_current_info_o;
  logic signed [7:0] mean_phase_current_o;
  logic neg_cur = 1'b0;
  logic slow = 1'b0;
  logic [1:0] hi_q = 2'h0;
  logic [31:0] rd;
  int vpct = 100;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int rises [2] = '{0, 0};

  dpvs_core #(.PER(PER), .SS_TICKS(4)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .voltage_code_i(voltage_code_i), .freq_stop_i(freq_stop_i),
    .switch_node_low_i(node_low), .low_gate_low_i(gate_low),
    .phase_current_info_i(phase_current_info_i), .vout_mv_i(vout_mv_i),
    .ton_demand_i(ton_demand_i), .drive_o(drive_o), .fault_o(fault_o),
    .output_ok_o(output_ok_o), .no_load_park_mode_o(no_load_park_mode_o),
    .setpoint_ref_o(setpoint_ref_o),
    .total_current_info_o(total_current_info_o),
    .mean_phase_current_o(mean_phase_current_o));
  dpvs_stage_model stage_u (.clk_i(clk_i), .drive_i(drive_o),
    .neg_cur_i(neg_cur), .slow_i(slow), .node_low_o(node_low),
    .gate_low_o(gate_low));

  always #50 clk_i = ~clk_i;
  // output sense follows the set-point, scaled to provoke trips
  always @(posedge clk_i) begin
    vout_mv_i <= rst_i ? 11'h000 : 11'(int'(setpoint_ref_o) * vpct / 100);
    hi_q <= {drive_o[1].high, drive_o[0].high};
    for (int p = 0; p < 2; p++) begin
      if (drive_o[p].high && !hi_q[p]) rises[p]++;
    end
    cycles++;
    if (cycles > 20000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] adr,
                    input logic [31:0] dat);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic per(input int n);
    repeat (n * PER) @(posedge clk_i);
  endtask
  task automatic count(input int n);
    rises = '{0, 0};
    per(n);
  endtask
  function automatic logic [10:0] mv(input int c);
    return 11'(dpvs_pkg::VMAX_MV - dpvs_pkg::STEP_MV * c);
  endfunction
  task automatic wait_ref(input int c);
    int n;
    n = 0;
    while (setpoint_ref_o !== mv(c) && n < 40 * PER) begin
      @(posedge clk_i);
      n++;
    end
    check(setpoint_ref_o, mv(c));
  endtask
  task automatic do_reset;
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    do_reset();
    wb(1'b0, dpvs_pkg::ADR_CTRL, 32'h0);
    check(rd, 32'h4);
    wb(1'b1, dpvs_pkg::ADR_CTRL, 32'hE);
    wb(1'b0, dpvs_pkg::ADR_CTRL, 32'h0);
    check(rd, 32'hE);
    wb(1'b1, 4'h2, 32'hFF);
    wb(1'b0, 4'h2, 32'h0);
    check(rd, 32'h0);
    per(2);
    check(setpoint_ref_o, mv(4));
    check(output_ok_o, 1'b0);
    per(6);
    check(output_ok_o, 1'b1);
    count(4);
    check(rises[0], 4);
    check(rises[1], 4);
    phase_current_info_i[1] <= 8'sd20;
    per(3);
    check(total_current_info_o, 9'sd30);
    check(mean_phase_current_o, 8'sd15);
    wb(1'b0, dpvs_pkg::ADR_CURR, 32'h0);
    check(rd, 32'h140A);
    voltage_code_i <= 5'h06;
    repeat (PER) @(posedge clk_i);
    voltage_code_i <= 5'h04;
    per(4);
    check(setpoint_ref_o, mv(4));
    voltage_code_i <= 5'h08;
    wait_ref(5);
    voltage_code_i <= 5'h0C;
    check(output_ok_o, 1'b0);
    wait_ref(8);
    per(2);
    check(setpoint_ref_o, mv(8));
    wait_ref(12);
    repeat (3) @(posedge clk_i);
    check(output_ok_o, 1'b1);
    neg_cur <= 1'b1;
    slow <= 1'b1;
    count(4);
    check(rises[0], 4);
    neg_cur <= 1'b0;
    phase_current_info_i[0] <= 8'sd35;
    per(2);
    count(2);
    check(rises[0] != 0, 1'b1);
    phase_current_info_i[0] <= 8'sd36;
    per(2);
    count(3);
    check(rises[0], 0);
    check(rises[1] != 0, 1'b1);
    wb(1'b0, dpvs_pkg::ADR_STAT, 32'h0);
    check(rd[6:5], 2'b01);
    phase_current_info_i[0] <= 8'sd10;
    per(2);
    count(2);
    check(rises[0] != 0, 1'b1);
    freq_stop_i <= 1'b1;
    per(1);
    count(3);
    check(rises[0] + rises[1], 0);
    freq_stop_i <= 1'b0;
    wb(1'b1, dpvs_pkg::ADR_CTRL, 32'hF);
    per(1);
    count(3);
    check(rises[0] + rises[1], 0);
    wb(1'b0, dpvs_pkg::ADR_STAT, 32'h0);
    check(rd[7], 1'b0);
    wb(1'b1, dpvs_pkg::ADR_CTRL, 32'hE);
    per(2);
    vpct = 50;
    per(4);
    check(fault_o, 1'b1);
    check({drive_o[0], drive_o[1]}, 4'h0);
    vpct = 100;
    per(2);
    check(fault_o, 1'b1);
    do_reset();
    per(3);
    vpct = 125;
    per(1);
    check(fault_o, 1'b1);
    check({drive_o[0].low, drive_o[1].low}, 2'b11);
    vpct = 100;
    do_reset();
    voltage_code_i <= 5'h1F;
    per(3);
    check(no_load_park_mode_o, 1'b1);
    voltage_code_i <= 5'h04;
    vpct = 50;
    per(4);
    check({no_load_park_mode_o, fault_o}, 2'b10);
    check({drive_o[0], drive_o[1]}, 4'h0);
    tally_and_finish();
  end
endmodule

/* File: testbench/dpvs_stage_model.sv */
`timescale 1ns/1ps
module dpvs_stage_model (
  // clock
  input wire logic clk_i,
  // gate drives and stage conditions
  input wire dpvs_pkg::dpvs_drive_t drive_i [2],
  input wire logic neg_cur_i,
  input wire logic slow_i,
  // comparator pins
  output logic [1:0] node_low_o,
  output logic [1:0] gate_low_o
);
  logic [1:0] node_now;
  logic [1:0] node_d;
  initial begin
    node_low_o = 2'h3;
    gate_low_o = 2'h3;
    node_d = 2'h3;
  end
  // reversed current keeps the node up until the low side clamps it
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      node_now[p] = !drive_i[p].high
        && (!neg_cur_i || drive_i[p].low);
    end
  end
  always @(posedge clk_i) begin
    node_d <= node_now;
    node_low_o <= slow_i ? node_d : node_now;
    gate_low_o <= {!drive_i[1].low, !drive_i[0].low};
  end
endmodule
